// *** src/htim_pkg.sv ***
// Package of offsets, fields and reset values for the host timer block
package htim_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFS_CFG         = 8'h8c;
   localparam logic [7:0]  OFS_CNT         = 8'h90;
   localparam logic [7:0]  OFS_TICK        = 8'h9c;
   localparam logic [7:0]  OFS_STS         = 8'hb8;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int          CFG_RUN_BIT     = 29;
   localparam logic [15:0] PRELOAD_RST     = 16'hffff;
   localparam logic [15:0] COUNT_RST       = 16'hffff;
   localparam logic [31:0] TICK_RST        = 32'h0000_0000;
   localparam int          STS_TIMER_BIT   = 0;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 40;
   localparam int          TICK_CLEAR_NS   = 160;
   localparam int          TICK_CLEAR_CYC  = (TICK_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** src/htim_tick_if.sv ***
// Interface carrying tick counter controls and value
`timescale 1ns/1ps
`default_nettype none
interface htim_tick_if;
   logic        enable;
   logic        capture;
   logic [31:0] value;
   logic [31:0] held;
   modport owner (input enable, input capture, output value, output held);
   modport user  (output enable, output capture, input value, input held);
endinterface
`default_nettype wire

// *** src/htim_tick.sv ***
// Free-running 32-bit tick counter with read capture
`timescale 1ns/1ps
`default_nettype none
module htim_tick (
   input  wire logic     clk,
   input  wire logic     rst,
   htim_tick_if.owner    tk
);
   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Power state never gates this; only the clock enable freezes it
   always_ff @(posedge clk) begin
      if (rst) begin
         tk.value <= htim_pkg::TICK_RST;
      end else if (tk.enable) begin
         tk.value <= tk.value + 32'h0000_0001;
      end
   end
   // ----------------------------------------------------------------
   // Capture for the second half-word
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         tk.held <= htim_pkg::TICK_RST;
      end else if (tk.enable && tk.capture) begin
         tk.held <= tk.value;
      end
   end
endmodule
`default_nettype wire

// *** src/htim_top.sv ***
// Host timer and tick counter, SRAM-like 16-bit register port
//
// Notes on behaviour
// - Writing one to the run bit starts the interval timer, clearing it halts the count.
// - A one-to-zero change of the run bit forces the preload field back to all ones.
// - The low 16 bits of the config register hold the preload, reset to all ones, read and write.
// - The count register always returns the present timer count, all ones after reset.
// - While running the timer raises host events repeatedly, once every preload plus one cycles.
// - The tick counter is 32 bits, starts at zero after reset and adds one each clock with CE high.
// - At its largest value the tick counter wraps to zero and keeps going.
// - The low half-word read of the tick counter captures all 32 bits, the high half comes from it.
// - The tick counter may take up to 160 ns after reset to read zero.
// - Power states never stop the tick counter.
`timescale 1ns/1ps
`default_nettype none
module htim_top (
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        CS_N,
   input  wire logic        RD_N,
   input  wire logic        WR_N,
   input  wire logic [7:1]  ADDR,
   input  wire logic [15:0] DIN,
   output var  logic [15:0] DOUT,
   output var  logic        DOUT_EN,
   output var  logic        TIMER_EVENT,
   output var  logic        TIMER_FLAG
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] strb_s1_reg;
   logic [2:0] strb_s2_reg;
   logic [2:0] strb_prev_reg;
   logic [7:1] addr_s1_reg;
   logic [7:1] addr_s2_reg;
   logic [15:0] din_s1_reg;
   logic [15:0] din_s2_reg;
   // Strobes reset to their idle level, so no false leading edge follows reset
   always_ff @(posedge MCLK) begin
      if (RST) begin
         strb_s1_reg   <= 3'h7;
         strb_s2_reg   <= 3'h7;
         strb_prev_reg <= 3'h7;
      end else if (CE) begin
         strb_s1_reg   <= {CS_N, RD_N, WR_N};
         strb_s2_reg   <= strb_s1_reg;
         strb_prev_reg <= strb_s2_reg;
      end
   end

   // Host holds address and data across the strobe; they share its two stages
   always_ff @(posedge MCLK) begin
      if (RST) begin
         addr_s1_reg <= 7'h00;
         addr_s2_reg <= 7'h00;
      end else if (CE) begin
         addr_s1_reg <= ADDR;
         addr_s2_reg <= addr_s1_reg;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         din_s1_reg <= 16'h0000;
         din_s2_reg <= 16'h0000;
      end else if (CE) begin
         din_s1_reg <= DIN;
         din_s2_reg <= din_s1_reg;
      end
   end
   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   logic       rd_act;
   logic       wr_act;
   logic       rd_start;
   logic       wr_start;
   logic [7:0] byte_addr;
   logic       half_hi;
   assign rd_act    = !strb_s2_reg[2] && !strb_s2_reg[1];
   assign wr_act    = !strb_s2_reg[2] && !strb_s2_reg[0];
   // Act once per strobe, at its leading edge
   assign rd_start  = rd_act && !(!strb_prev_reg[2] && !strb_prev_reg[1]);
   assign wr_start  = wr_act && !(!strb_prev_reg[2] && !strb_prev_reg[0]);
   // Half-word address folded onto the 32-bit register offsets
   assign byte_addr = {addr_s2_reg[7:2], 2'b00};
   assign half_hi   = addr_s2_reg[1];

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Addressed half of a 32-bit register image
   function automatic logic [15:0] half_of(input logic [31:0] w, input logic hi);
      half_of = hi ? w[31:16] : w[15:0];
   endfunction
   // ----------------------------------------------------------------
   // Interval timer
   // ----------------------------------------------------------------
   logic [15:0] preload_reg;
   logic        run_reg;
   logic [15:0] count_reg;
   logic        wr_cfg_lo;
   logic        wr_cfg_hi;
   logic        run_next;
   logic        expire;
   assign wr_cfg_lo = wr_start && hit(byte_addr, htim_pkg::OFS_CFG) && !half_hi;
   assign wr_cfg_hi = wr_start && hit(byte_addr, htim_pkg::OFS_CFG) && half_hi;
   assign run_next  = wr_cfg_hi ? din_s2_reg[htim_pkg::CFG_RUN_BIT - 16] : run_reg;
   // Reload lands one cycle after zero, so the period is preload plus one
   assign expire    = run_reg && (count_reg == 16'h0000);

   // Run bit takes effect at the edge that acts on the write
   always_ff @(posedge MCLK) begin
      if (RST) begin
         run_reg <= 1'b0;
      end else if (CE) begin
         run_reg <= run_next;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         preload_reg <= htim_pkg::PRELOAD_RST;
      end else if (CE) begin
         if (run_reg && !run_next) begin
            preload_reg <= htim_pkg::PRELOAD_RST;
         end else if (wr_cfg_lo) begin
            preload_reg <= din_s2_reg;
         end
      end
   end

   // Halted timer holds its count; a start reloads from preload
   always_ff @(posedge MCLK) begin
      if (RST) begin
         count_reg <= htim_pkg::COUNT_RST;
      end else if (CE) begin
         if (!run_reg && run_next) begin
            count_reg <= preload_reg;
         end else if (expire) begin
            count_reg <= preload_reg;
         end else if (run_reg) begin
            count_reg <= count_reg - 16'h0001;
         end
      end
   end
   // ----------------------------------------------------------------
   // Timer status and event outputs
   // ----------------------------------------------------------------
   logic clr_flag;
   assign clr_flag = wr_start && hit(byte_addr, htim_pkg::OFS_STS) && !half_hi
                     && din_s2_reg[htim_pkg::STS_TIMER_BIT];
   always_ff @(posedge MCLK) begin
      if (RST) begin
         TIMER_EVENT <= 1'b0;
      end else if (CE) begin
         TIMER_EVENT <= expire;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         TIMER_FLAG <= 1'b0;
      end else if (CE) begin
         // Set wins over a write-one clear in the same cycle
         if (expire) begin
            TIMER_FLAG <= 1'b1;
         end else if (clr_flag) begin
            TIMER_FLAG <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Tick counter
   // ----------------------------------------------------------------
   htim_tick_if tick ();
   logic first_tick_rd;
   // A lone high-half read returns whatever the last low-half read captured
   assign first_tick_rd = rd_start && hit(byte_addr, htim_pkg::OFS_TICK) && !half_hi;
   assign tick.enable   = CE;
   assign tick.capture  = first_tick_rd;

   htim_tick u_tick (
      .clk (MCLK),
      .rst (RST),
      .tk  (tick.owner)
   );
   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [15:0] rdata;
   always_comb begin
      rdata = 16'h0000;
      if (hit(byte_addr, htim_pkg::OFS_CFG)) begin
         rdata = half_of({2'b00, run_reg, 13'h0000, preload_reg}, half_hi);
      end else if (hit(byte_addr, htim_pkg::OFS_CNT)) begin
         rdata = half_of({16'h0000, count_reg}, half_hi);
      end else if (hit(byte_addr, htim_pkg::OFS_TICK)) begin
         // Low half comes live and is captured together with it
         rdata = half_of({tick.held[31:16], tick.value[15:0]}, half_hi);
      end else if (hit(byte_addr, htim_pkg::OFS_STS)) begin
         rdata = half_of({31'h0000_0000, TIMER_FLAG}, half_hi);
      end
   end

   // Enable follows the synced strobe level, so a held read keeps driving
   always_ff @(posedge MCLK) begin
      if (RST) begin
         DOUT_EN <= 1'b0;
      end else if (CE) begin
         DOUT_EN <= rd_act;
      end
   end

   // Data loads once per strobe and then holds, even if its source moves
   always_ff @(posedge MCLK) begin
      if (RST) begin
         DOUT <= 16'h0000;
      end else if (CE && rd_start) begin
         DOUT <= rdata;
      end
   end
endmodule
`default_nettype wire

// *** verif/htim_top_sva.sv ***
// Port checker for the host timer block
`timescale 1ns/1ps
`default_nettype none
module htim_top_sva (
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic        CS_N,
   input wire logic        RD_N,
   input wire logic        WR_N,
   input wire logic [7:1]  ADDR,
   input wire logic [15:0] DIN,
   input wire logic [15:0] DOUT,
   input wire logic        DOUT_EN,
   input wire logic        TIMER_EVENT,
   input wire logic        TIMER_FLAG
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   wire rd_act = !(CS_N | RD_N);
   a_reset_idle: assert property ($fell(RST) |-> !DOUT_EN && !TIMER_FLAG && DOUT == 16'h0000)
      else $error("outputs not idle after reset");
   a_boot_quiet: assert property ($fell(RST) |-> !TIMER_EVENT [*8])
      else $error("event before timer started");
   a_event_flag: assert property (TIMER_EVENT |-> TIMER_FLAG)
      else $error("event without status flag");
   a_flag_sticky: assert property (TIMER_FLAG && WR_N |=> TIMER_FLAG)
      else $error("flag lost without write");
   a_read_drive: assert property ($rose(rd_act) |-> ##[2:4] DOUT_EN)
      else $error("read not driven");
   a_read_release: assert property ($fell(rd_act) |-> ##[2:4] !DOUT_EN)
      else $error("read not released");
   a_dout_holds: assert property (!$rose(DOUT_EN) |-> $stable(DOUT))
      else $error("read data moved");
   a_bus_quiet: assert property (CS_N [*6] |-> !DOUT_EN)
      else $error("drive while deselected");
   c_event: cover property (TIMER_EVENT);
   c_read: cover property ($rose(DOUT_EN));
   c_clear: cover property ($fell(TIMER_FLAG));
endmodule
`default_nettype wire

// *** verif/htim_host_model.sv ***
// Host processor model on the half-word strobe bus
`timescale 1ns/1ps
`default_nettype none
module htim_host_model (
   input  wire logic        clk,
   input  wire logic [15:0] dout,
   input  wire logic        dout_en,
   output var  logic        cs_n = 1'b1,
   output var  logic        rd_n = 1'b1,
   output var  logic        wr_n = 1'b1,
   output var  logic [7:1]  addr = 7'h00,
   output var  logic [15:0] din = 16'h0000,
   output var  logic        hung = 1'b0
);
   // Strobes held 4 cycles, gap 4: no ready pin exists
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a[7:1];
      din = d;
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
      din = ~d;
      repeat (4) @(negedge clk);
   endtask
   // One half-word read; strobe held until the enable answers, then gap 4
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      int n;
      @(negedge clk);
      addr = a[7:1];
      cs_n = 1'b0;
      rd_n = 1'b0;
      n = 0;
      // Poll at the falling edge, where the registered answer has settled
      do begin
         @(negedge clk);
         n++;
      end while (dout_en !== 1'b1 && n < 10);
      hung = hung | (n >= 10);
      d = dout;
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   task automatic boot;
      repeat (htim_pkg::TICK_CLEAR_CYC) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// *** verif/htim_top_tb.sv ***
// Self-checking bench for the host timer block
`timescale 1ns/1ps
`default_nettype none
module htim_top_tb;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        cs_n, rd_n, wr_n, dout_en, tev, tflag, hung;
   logic [7:1]  addr;
   logic [15:0] din, dout, v, w;
   int          n_errors = 0;
   int          total_checks = 0;
   int          c;
   time         t0, t1, t_rel;
   always #20 mclk = ~mclk;
   htim_top htim_top_inst (.MCLK(mclk), .RST(rst), .CE(ce), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
      .ADDR(addr), .DIN(din), .DOUT(dout), .DOUT_EN(dout_en), .TIMER_EVENT(tev), .TIMER_FLAG(tflag));
   htim_host_model htim_host_model_inst (.clk(mclk), .dout(dout), .dout_en(dout_en), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .din(din), .hung(hung));
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp || hung !== 1'b0) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic get(input logic [7:0] a, output logic [15:0] d);
      htim_host_model_inst.rd(a, d);
      if (hung !== 1'b0) begin
         n_errors++;
         $display("[FAIL] %0t read not answered", $time);
         test_done();
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [15:0] e);
      get(a, v);
      cmp(v, e);
   endtask
   // Capture lands on the fourth rising edge after the call: one before the strobe, two sync stages, then the acting edge
   task automatic tick_now;
      t0 = $time;
      get(8'h9c, v);
      cmp(v, 16'((t0 - t_rel) / htim_pkg::CLK_PERIOD_NS + 3));
   endtask
   task automatic wait_ev;
      c = 0;
      do begin
         @(negedge mclk);
         c++;
      end while (tev !== 1'b1 && c < 100);
      if (c >= 100) begin
         n_errors++;
         $display("[FAIL] %0t no timer event", $time);
         test_done();
      end
   endtask
   task automatic t_reset;
      chk(8'h8c, 16'hffff);
      chk(8'h8e, 16'h0000);
      chk(8'h92, 16'h0000);
      chk(8'hb8, 16'h0000);
      chk(8'ha0, 16'h0000);
      htim_host_model_inst.wr(8'h90, 16'h1234);
      chk(8'h90, 16'hffff);
      $display("t_reset done");
   endtask
   task automatic t_tick;
      tick_now();
      t1 = $time;
      get(8'h9c, w);
      cmp(w - v, 16'((t1 - t0) / htim_pkg::CLK_PERIOD_NS));
      chk(8'h9e, 16'h0000);
      $display("t_tick done");
   endtask
   task automatic t_timer;
      htim_host_model_inst.wr(8'h8c, 16'h0009);
      chk(8'h8c, 16'h0009);
      htim_host_model_inst.wr(8'h8e, 16'h2000);
      wait_ev();
      wait_ev();
      cmp(16'(c), 16'h000a);
      chk(8'hb8, 16'h0001);
      cmp({15'h0000, tflag}, 16'h0001);
      htim_host_model_inst.wr(8'h8e, 16'h0000);
      chk(8'h8c, 16'hffff);
      get(8'h90, w);
      chk(8'h90, w);
      htim_host_model_inst.wr(8'hb8, 16'h0001);
      chk(8'hb8, 16'h0000);
      cmp({15'h0000, tflag}, 16'h0000);
      c = 0;
      repeat (40) @(negedge mclk) c += int'(tev === 1'b1);
      cmp(16'(c), 16'h0000);
      $display("t_timer done");
   endtask
   task automatic t_freeze;
      t0 = $time;
      get(8'h9c, v);
      ce = 1'b0;
      repeat (20) @(negedge mclk);
      ce = 1'b1;
      t1 = $time;
      get(8'h9c, w);
      cmp(w - v, 16'((t1 - t0) / htim_pkg::CLK_PERIOD_NS - 20));
      $display("t_freeze done");
   endtask
   task automatic t_rerun;
      htim_host_model_inst.wr(8'h8c, 16'h1234);
      rst = 1'b1;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      t_rel = $time;
      htim_host_model_inst.boot();
      tick_now();
      chk(8'h8c, 16'hffff);
      chk(8'h90, 16'hffff);
      chk(8'h8e, 16'h0000);
      $display("t_rerun done");
   endtask
   initial begin
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      t_rel = $time;
      htim_host_model_inst.boot();
      t_reset();
      t_tick();
      t_timer();
      t_freeze();
      t_rerun();
      test_done();
   end
endmodule
bind htim_top htim_top_sva htim_top_sva_inst (.MCLK(MCLK), .RST(RST), .CE(CE), .CS_N(CS_N), .RD_N(RD_N),
   .WR_N(WR_N), .ADDR(ADDR), .DIN(DIN), .DOUT(DOUT), .DOUT_EN(DOUT_EN), .TIMER_EVENT(TIMER_EVENT),
   .TIMER_FLAG(TIMER_FLAG));
`default_nettype wire
